// ==== hw/ss_sel_pkg.sv ====
// Constants shared by the start/stop source selector and its helpers.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz system clock.
package ss_sel_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int         ADDR_W     = 8;

  // Control register fields.
  localparam int         SRC_LSB    = 0;
  localparam int         SRC_W      = 5;
  localparam int         DIRSET_LSB = 8;
  localparam int         DIRSET_W   = 2;

  // Status register fields.
  localparam int         ST_RUN     = 0;
  localparam int         ST_REV     = 1;
  localparam int         ST_VALID   = 2;
  localparam int         ST_LOC     = 3;
  localparam int         ST_DI_LSB  = 8;

  // Reset values of the control fields.
  localparam logic [4:0] SRC_RST    = 5'h00;
  localparam logic [1:0] DIRSET_RST = 2'h3;

  // Source codes.
  localparam logic [4:0] SRC_NONE   = 5'h00;
  localparam logic [4:0] SRC_PANEL  = 5'h08;
  localparam logic [4:0] SRC_FWDREV = 5'h09;
  localparam logic [4:0] SRC_BUS    = 5'h0A;
  localparam logic [4:0] SRC_SCHED1 = 5'h0B;
  localparam logic [4:0] SRC_SCHED4 = 5'h0E;
  localparam logic [4:0] SRC_LINE5  = 5'h14;
  localparam logic [4:0] SRC_L5L4   = 5'h15;
  localparam logic [4:0] SRC_TSTOP  = 5'h16;
  localparam logic [4:0] SRC_TSTART = 5'h17;
  localparam logic [4:0] SRC_CSTOP  = 5'h18;

  // Direction setting codes.
  localparam logic [1:0] DIR_FWD    = 2'h1;
  localparam logic [1:0] DIR_REV    = 2'h2;
  localparam logic [1:0] DIR_REQ    = 2'h3;

  // Fieldbus command word bit positions.
  localparam int         BUS_START_BIT = 0;
  localparam int         BUS_STOP_BIT  = 1;

  // Number of digital input lines and synchroniser depth.
  localparam int         NUM_LINES  = 5;
  localparam int         SYNC_DEPTH = 2;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ss_sel_pkg

// ==== hw/line_sync.sv ====
// Two-flop synchronisers for a group of asynchronous input pins.
// Assumes the pins may change at any time relative to sys_clk.
`timescale 1ns/100ps
module line_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  // One chain per line; the first stage feeds only the second.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      logic meta_r;
      logic sync_r;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= pin_in[i];
          sync_r <= meta_r;
        end
      end
      assign pin_sync[i] = sync_r;
    end
  endgenerate

endmodule : line_sync

// ==== hw/run_hold.sv ====
// Bank of set/clear run latches, one per latched start/stop source.
// Assumes set and clear come from logic on sys_clk.
`timescale 1ns/100ps
module run_hold #(
  parameter int N = 3
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] sel,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] hold
);

  // Clear wins over set so a stop is never missed; a deselected
  // latch is forced low so a stale run cannot survive a source change.
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_hold
      logic hold_r;
      always_ff @(posedge sys_clk) begin
        if (!rst_n || !sel[i] || clr[i]) begin
          hold_r <= 1'b0;
        end else if (set[i]) begin
          hold_r <= 1'b1;
        end
      end
      assign hold[i] = hold_r;
    end
  endgenerate

endmodule : run_hold

// ==== hw/start_stop_source_selector.sv ====
// Start/stop/direction source selector for the first external control location.
// Assumes AXI4-Lite on sys_clk, digital input lines straight from pins, and
// panel, fieldbus, schedule, timer and counter signals from logic on sys_clk.
//
// Notes on behaviour
// - Source 8 with location one active takes run, stop, direction from panel.
// - Panel direction requests count only when direction setting is request.
// - Source 9 with request setting: line one only forward, line two only reverse, else stop.
// - Source 10: start and stop from bus command word one bits 0 and 1.
// - Sources 11 to 14 run while the matching scheduled function is active.
// - Source 20: run while line five high, forward unless setting is fixed reverse.
// - Source 21: line five runs, line four reverse only with request setting.
// - Source 22: start on timer start signal, stop when timer delay elapses.
// - Source 23: start when timer delay elapses, stop on timer reset.
// - Source 24: start on counter start signal, stop past counter limit.
// - Source 0 selects nothing, so no command is produced.
// - Direction setting: 1 fixed forward, 2 fixed reverse, 3 selectable.
`timescale 1ns/100ps
module start_stop_source_selector (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Digital input pins one to five, bit 0 is line one.
  input  wire logic [4:0]  input_lines,
  // Location and panel.
  input  wire logic        external_location_one,
  input  wire logic        panel_start,
  input  wire logic        panel_stop,
  input  wire logic        panel_reverse_req,
  // Fieldbus, schedule, timer and counter helpers.
  input  wire logic [15:0] bus_command_word_one,
  input  wire logic [3:0]  scheduled_function,
  input  wire logic        timer_start_sig,
  input  wire logic        timer_elapsed,
  input  wire logic        timer_reset,
  input  wire logic        count_run_signal,
  input  wire logic        count_over_limit,
  // Commands to the motor control core.
  output logic             run_cmd,
  output logic             reverse_cmd,
  output logic             source_valid
);

  // Registers.
  // Every command output is a flip-flop, so the core
  // never sees a decode glitch when the code changes.
  // Bus channel state sits beside its own channel.
  logic [4:0]  src_r;
  logic [1:0]  dirset_r;
  logic        run_r;
  logic        reverse_r;
  logic        valid_r;

  // Write channel state.
  logic        aw_held_r;
  logic [7:0]  awaddr_r;
  logic        w_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  // Read channel state.
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // Input synchronisers for the pin inputs.
  // Only the pin lines come from outside this clock domain.
  // The other inputs already run on sys_clk.
  // The two stages cost two cycles on every line source.
  logic [4:0]  lines_s;

  line_sync #(
    .WIDTH (ss_sel_pkg::NUM_LINES)
  ) u_line_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   (input_lines),
    .pin_sync (lines_s)
  );

  // Named views of the synchronised lines.
  wire line_one  = lines_s[0];
  wire line_two  = lines_s[1];
  wire line_four = lines_s[3];
  wire line_five = lines_s[4];

  // Source decode. Exactly one of these is high for a valid code.
  // Each select is a plain compare on the stored code, so
  // two sources can never be active together.
  // Uncovered codes fall through and act as no source.
  wire sel_none   = (src_r == ss_sel_pkg::SRC_NONE);
  wire sel_panel  = (src_r == ss_sel_pkg::SRC_PANEL);
  wire sel_fwdrev = (src_r == ss_sel_pkg::SRC_FWDREV);
  wire sel_bus    = (src_r == ss_sel_pkg::SRC_BUS);
  wire sel_sched  = (src_r >= ss_sel_pkg::SRC_SCHED1) &&
                    (src_r <= ss_sel_pkg::SRC_SCHED4);
  wire sel_line5  = (src_r == ss_sel_pkg::SRC_LINE5);
  wire sel_l5l4   = (src_r == ss_sel_pkg::SRC_L5L4);
  wire sel_tstop  = (src_r == ss_sel_pkg::SRC_TSTOP);
  wire sel_tstart = (src_r == ss_sel_pkg::SRC_TSTART);
  wire sel_cstop  = (src_r == ss_sel_pkg::SRC_CSTOP);

  // Codes outside the covered set produce no command, like code 0.
  wire sel_known  = sel_panel | sel_fwdrev | sel_bus | sel_sched | sel_line5 |
                    sel_l5l4 | sel_tstop | sel_tstart | sel_cstop;

  // Index of the scheduled function for codes 11..14.
  wire [4:0] sched_ofs = src_r - ss_sel_pkg::SRC_SCHED1;
  wire [1:0] sched_idx = sched_ofs[1:0];

  // Latched sources: panel, timer stop, timer start, counter stop.
  // A latch only listens while its own source is selected.
  // These sources give events, not levels, so the run
  // state is held here between a start and its stop.
  // Clearing on deselect stops a stale run returning.
  logic [3:0] hold_sel;
  logic [3:0] hold_set;
  logic [3:0] hold_clr;
  logic [3:0] hold_q;

  // The panel latch also drops when location one goes inactive.
  assign hold_sel = {sel_cstop, sel_tstart, sel_tstop,
                     sel_panel & external_location_one};
  assign hold_set = {count_run_signal, timer_elapsed,
                     timer_start_sig, panel_start};
  assign hold_clr = {count_over_limit, timer_reset,
                     timer_elapsed, panel_stop};

  run_hold #(
    .N (4)
  ) u_run_hold (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sel     (hold_sel),
    .set     (hold_set),
    .clr     (hold_clr),
    .hold    (hold_q)
  );

  // Run request per source, then one selected by the source code.
  // An AND-OR mux keeps unselected sources at zero.
  // A source that is not selected cannot reach the core.
  // Levels pass straight through; only the output is registered.
  wire run_fwdrev = line_one ^ line_two;
  wire bus_run    = bus_command_word_one[ss_sel_pkg::BUS_START_BIT] &
                    ~bus_command_word_one[ss_sel_pkg::BUS_STOP_BIT];
  wire sched_run  = scheduled_function[sched_idx];

  // Only the selected source reaches the run request.
  wire run_req = (sel_panel  & hold_q[0]) |
                 (sel_fwdrev & run_fwdrev) |
                 (sel_bus    & bus_run) |
                 (sel_sched  & sched_run) |
                 (sel_line5  & line_five) |
                 (sel_l5l4   & line_five) |
                 (sel_tstop  & hold_q[1]) |
                 (sel_tstart & hold_q[2]) |
                 (sel_cstop  & hold_q[3]);

  // Direction. Sources with a direction input raise a reverse request;
  // it is honoured only under the request setting. Otherwise the
  // setting fixes direction, with request meaning forward.
  // A fixed reverse setting applies to every source.
  // Direction is shown only while a source is active.
  // Source 9 outside the request setting runs in the fixed direction.
  wire dir_is_req = (dirset_r == ss_sel_pkg::DIR_REQ);
  wire dir_is_rev = (dirset_r == ss_sel_pkg::DIR_REV);

  // Source 9 needs the request setting for line two to reverse; software keeps it so.
  wire rev_req = (sel_panel  & panel_reverse_req) |
                 (sel_fwdrev & line_two & ~line_one) |
                 (sel_l5l4   & line_four);

  // Fixed sources (20, schedules, bus, timers, counter) see forward
  // unless the setting itself is fixed reverse.
  wire reverse_nxt = dir_is_req ? rev_req : dir_is_rev;

  // Whole command is gated by the location and by a valid source.
  wire active_nxt  = external_location_one & sel_known & ~sel_none;
  wire run_nxt     = active_nxt & run_req;

  // Command outputs are registered so the core sees clean levels.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_r     <= 1'b0;
      reverse_r <= 1'b0;
      valid_r   <= 1'b0;
    end else begin
      run_r     <= run_nxt;
      reverse_r <= active_nxt & reverse_nxt;
      valid_r   <= active_nxt;
    end
  end

  assign run_cmd      = run_r;
  assign reverse_cmd  = reverse_r;
  assign source_valid = valid_r;

  // AXI4-Lite write path. Address and data are taken in either order
  // and held until both are present; the response follows one cycle
  // after the second of them.
  // Both readies stay low while a response waits, so a
  // new write cannot overtake an unread answer.
  // Only the control word is writable.
  // Status writes answer with an error and change nothing.
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire aw_have  = aw_held_r | aw_take;
  wire w_have   = w_held_r | w_take;
  wire [7:0]  wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_fire  = aw_have & w_have & ~bvalid_r;
  wire wr_ctrl  = wr_fire & (wr_addr == ss_sel_pkg::CTRL_OFS);
  wire wr_stat  = wr_fire & (wr_addr == ss_sel_pkg::STATUS_OFS);
  wire wr_known = wr_ctrl | wr_stat;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // Control fields after a byte-masked write.
  wire [4:0] src_nxt    = wr_strb[0] ? wr_data[ss_sel_pkg::SRC_LSB +: ss_sel_pkg::SRC_W] : src_r;
  wire [1:0] dirset_nxt = wr_strb[1] ? wr_data[ss_sel_pkg::DIRSET_LSB +: ss_sel_pkg::DIRSET_W]
                                     : dirset_r;

  // Holding registers for a half-arrived write.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      aw_held_r <= aw_have & ~wr_fire;
      w_held_r  <= w_have & ~wr_fire;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // Write response; status is read-only and answers with an error.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= ss_sel_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ctrl ? ss_sel_pkg::RESP_OKAY : ss_sel_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Control register. A new source code takes effect on the next
  // cycle and drops every latched run of the old source.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      src_r    <= ss_sel_pkg::SRC_RST;
      dirset_r <= ss_sel_pkg::DIRSET_RST;
    end else if (wr_ctrl) begin
      src_r    <= src_nxt;
      dirset_r <= dirset_nxt;
    end
  end

  // AXI4-Lite read path. One read at a time, answered next cycle.
  // Read data are a snapshot taken at acceptance.
  // Unmapped offsets answer with an error and zero data.
  // Waiting answers hold until the master takes them.
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_ctrl = (s_axi_araddr == ss_sel_pkg::CTRL_OFS);
  wire rd_stat = (s_axi_araddr == ss_sel_pkg::STATUS_OFS);

  // Status word shows the block's live command and the sampled lines.
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[ss_sel_pkg::SRC_LSB +: ss_sel_pkg::SRC_W]       = src_r;
    ctrl_word[ss_sel_pkg::DIRSET_LSB +: ss_sel_pkg::DIRSET_W] = dirset_r;
    stat_word = 32'h0000_0000;
    stat_word[ss_sel_pkg::ST_RUN]   = run_r;
    stat_word[ss_sel_pkg::ST_REV]   = reverse_r;
    stat_word[ss_sel_pkg::ST_VALID] = valid_r;
    stat_word[ss_sel_pkg::ST_LOC]   = external_location_one;
    stat_word[ss_sel_pkg::ST_DI_LSB +: ss_sel_pkg::NUM_LINES] = lines_s;
  end

  wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0000_0000);
  wire [1:0]  rd_resp = (rd_ctrl | rd_stat) ? ss_sel_pkg::RESP_OKAY : ss_sel_pkg::RESP_SLVERR;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Read data is captured at acceptance and held until taken.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= ss_sel_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : start_stop_source_selector

// ==== tb/ss_sel_chk.sv ====
// Port checker for the start/stop source selector.
// Assumes the master offers write address and data in the same cycle.
`timescale 1ns/100ps
module ss_sel_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [4:0]  input_lines,
  input wire logic        external_location_one,
  input wire logic [15:0] bus_command_word_one,
  input wire logic        run_cmd,
  input wire logic        reverse_cmd,
  input wire logic        source_valid
);
  logic [4:0] src_r;
  logic [1:0] dir_r;
  logic       loc;
  wire        wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                       && s_axi_awaddr == ss_sel_pkg::CTRL_OFS;
  assign loc = external_location_one;

  // Shadow of the control register, so decode checks know the live source and direction.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      src_r <= ss_sel_pkg::SRC_RST;
      dir_r <= ss_sel_pkg::DIRSET_RST;
    end else if (wr_ctl) begin
      if (s_axi_wstrb[0]) src_r <= s_axi_wdata[4:0];
      if (s_axi_wstrb[1]) dir_r <= s_axi_wdata[9:8];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Pin lines need four stable samples to clear the synchroniser and output stage.
  a_fwdrev_reverse: assert property ((src_r == ss_sel_pkg::SRC_FWDREV && dir_r == ss_sel_pkg::DIR_REQ && loc
    && input_lines[1:0] == 2'b10) [*4] |-> run_cmd && reverse_cmd) else $error("line two did not run reverse");
  a_line5_fwd: assert property ((src_r == ss_sel_pkg::SRC_LINE5 && dir_r != ss_sel_pkg::DIR_REV && loc
    && input_lines[4]) [*4] |-> run_cmd && !reverse_cmd) else $error("line five did not run forward");
  a_bus_run: assert property ((src_r == ss_sel_pkg::SRC_BUS && loc
    && bus_command_word_one[1:0] == 2'b01) [*2] |-> run_cmd) else $error("bus start did not run");
  a_none_idle: assert property ((src_r == ss_sel_pkg::SRC_NONE) [*2] |-> !source_valid && !run_cmd)
    else $error("no source yet command given");
  a_loc_gate: assert property (!loc ##1 !loc |-> !run_cmd && !reverse_cmd && !source_valid)
    else $error("command while location inactive");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (wr_ctl |=> s_axi_bvalid)
    else $error("write not answered");

  cover property (src_r == ss_sel_pkg::SRC_PANEL && run_cmd && reverse_cmd);
  cover property (s_axi_bvalid && s_axi_bresp == ss_sel_pkg::RESP_SLVERR);
  cover property (src_r == ss_sel_pkg::SRC_CSTOP && run_cmd);
endmodule : ss_sel_chk

bind start_stop_source_selector ss_sel_chk i_chk (.*);

// ==== tb/far_side.sv ====
// Model of the digital input lines, the operator panel and the fieldbus controller.
// Assumes the bench calls set() from its main sequence.
`timescale 1ns/100ps
module far_side (
  input  wire logic   sys_clk,
  output logic [4:0]  input_lines = 5'h00,
  output logic        panel_start = 1'b0,
  output logic        panel_stop = 1'b0,
  output logic        panel_reverse_req = 1'b0,
  output logic [15:0] bus_command_word_one = 16'h0000
);
  // New levels land just after an edge, so the selector never sees a half change.
  task automatic set(input logic [4:0] l, input logic [2:0] p, input logic [15:0] w);
    @(posedge sys_clk);
    input_lines <= l;
    {panel_reverse_req, panel_stop, panel_start} <= p;
    bus_command_word_one <= w;
  endtask : set
endmodule : far_side

// ==== tb/start_stop_source_selector_tb_top.sv ====
// Self-checking bench for the start/stop source selector.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/100ps
module start_stop_source_selector_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [4:0]  input_lines;
  logic        panel_start, panel_stop, panel_reverse_req;
  logic [15:0] bus_command_word_one;
  logic        external_location_one = 1'b0;
  logic [3:0]  scheduled_function = 4'h0;
  logic [4:0]  aux = 5'h00;
  logic        run_cmd, reverse_cmd, source_valid;
  int          errors = 0;
  int          checks_done = 0;
  logic [2:0]  t9[4] = '{3'h1, 3'h5, 3'h7, 3'h1};
  int          st[3] = '{0, 1, 3};
  int          sp[3] = '{1, 2, 4};

  // Timer and counter helpers share one vector so a loop can pulse any of them.
  wire timer_start_sig = aux[0];
  wire timer_elapsed = aux[1];
  wire timer_reset = aux[2];
  wire count_run_signal = aux[3];
  wire count_over_limit = aux[4];

  start_stop_source_selector i_dut (.*);
  far_side i_far (.*);

  always #5 sys_clk = ~sys_clk;

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  // A wait that ran out means the slave hung, so the run stops there.
  task automatic guard(input logic ok);
    if (!ok) begin
      errors++;
      final_report();
    end
  endtask : guard

  // Bready is up from the start; the answer is taken at the edge where bvalid is seen high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int         n;
    logic       aw;
    logic       w;
    logic       got;
    logic [1:0] resp;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    got = 1'b0;
    resp = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      got = s_axi_bvalid;
      resp = s_axi_bresp;
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end while (!got && n < 50);
    guard(got);
    chk(resp, er);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int          n;
    logic        ar;
    logic        got;
    logic [31:0] data;
    logic [1:0]  resp;
    n = 0;
    ar = 1'b0;
    got = 1'b0;
    data = 32'h00000000;
    resp = 2'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      got = s_axi_rvalid;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      ar = ar | s_axi_arready;
      s_axi_arvalid <= !ar;
    end while (!got && n < 50);
    guard(got);
    chk(resp, er);
    chk(data, ed);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic sel(input logic [4:0] s, input logic [1:0] d);
    wr(ss_sel_pkg::CTRL_OFS, {22'h000000, d, 3'h0, s}, 4'h3, ss_sel_pkg::RESP_OKAY);
  endtask : sel

  // Five edges covers the slowest path, pin lines through the synchroniser.
  task automatic expect_out(input logic [2:0] e);
    repeat (5) @(posedge sys_clk);
    chk({run_cmd, reverse_cmd, source_valid}, e);
  endtask : expect_out

  task automatic pulse(input int b);
    aux <= 5'h01 << b;
    @(posedge sys_clk);
    aux <= 5'h00;
  endtask : pulse

  // Main sequence: registers first, then each source in turn.
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ss_sel_pkg::CTRL_OFS, 32'h00000300, ss_sel_pkg::RESP_OKAY);
    rd(ss_sel_pkg::STATUS_OFS, 32'h00000000, ss_sel_pkg::RESP_OKAY);
    rd(8'h08, 32'h00000000, ss_sel_pkg::RESP_SLVERR);
    wr(ss_sel_pkg::STATUS_OFS, 32'h00000001, 4'hF, ss_sel_pkg::RESP_SLVERR);
    external_location_one <= 1'b1;
    i_far.set(5'h1F, 3'h1, 16'h0001);
    expect_out(3'h0);
    sel(5'h01, ss_sel_pkg::DIR_REQ);
    expect_out(3'h0);
    sel(ss_sel_pkg::SRC_FWDREV, ss_sel_pkg::DIR_REQ);
    for (int i = 0; i < 4; i++) begin
      i_far.set(5'(i), 3'h0, 16'h0000);
      expect_out(t9[i]);
    end
    sel(ss_sel_pkg::SRC_BUS, ss_sel_pkg::DIR_REQ);
    for (int i = 0; i < 4; i++) begin
      i_far.set(5'h03, 3'h0, 16'(i));
      expect_out({i == 1, 2'b01});
    end
    for (int k = 0; k < 4; k++) begin
      sel(5'(ss_sel_pkg::SRC_SCHED1 + k), ss_sel_pkg::DIR_FWD);
      scheduled_function <= 4'h1 << k;
      expect_out(3'h5);
      scheduled_function <= ~(4'h1 << k);
      expect_out(3'h1);
    end
    scheduled_function <= 4'h0;
    sel(ss_sel_pkg::SRC_LINE5, ss_sel_pkg::DIR_REQ);
    i_far.set(5'h18, 3'h0, 16'h0000);
    expect_out(3'h5);
    rd(ss_sel_pkg::STATUS_OFS, 32'h0000180D, ss_sel_pkg::RESP_OKAY);
    for (int d = 1; d < 4; d++) begin
      sel(ss_sel_pkg::SRC_L5L4, 2'(d));
      expect_out({1'b1, d != 1, 1'b1});
    end
    sel(ss_sel_pkg::SRC_PANEL, ss_sel_pkg::DIR_REQ);
    i_far.set(5'h18, 3'h1, 16'h0000);
    i_far.set(5'h18, 3'h0, 16'h0000);
    expect_out(3'h5);
    i_far.set(5'h00, 3'h4, 16'h0000);
    expect_out(3'h7);
    wr(ss_sel_pkg::CTRL_OFS, {22'h000000, ss_sel_pkg::DIR_FWD, 8'h00}, 4'h2, ss_sel_pkg::RESP_OKAY);
    expect_out(3'h5);
    rd(ss_sel_pkg::CTRL_OFS, 32'h00000108, ss_sel_pkg::RESP_OKAY);
    i_far.set(5'h00, 3'h2, 16'h0000);
    expect_out(3'h1);
    i_far.set(5'h00, 3'h1, 16'h0000);
    external_location_one <= 1'b0;
    expect_out(3'h0);
    external_location_one <= 1'b1;
    i_far.set(5'h00, 3'h0, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      sel(5'(ss_sel_pkg::SRC_TSTOP + k), ss_sel_pkg::DIR_REQ);
      pulse(st[k]);
      expect_out(3'h5);
      pulse(sp[k]);
      expect_out(3'h1);
    end
    final_report();
  end
endmodule : start_stop_source_selector_tb_top
